// ---- hdl/pwm_gen_pkg.sv ----
// Shared constants and types of the multi-channel pulse generator
package pwm_gen_pkg;

  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int unsigned MCLK_HZ     = 25_000_000;   // System clock rate in hertz
  localparam int unsigned PRESC_W     = 18;           // Prescaler counter width
  localparam logic [4:0]  SEL_MAX     = 5'h12;        // Slowest rate select, 25 MHz / 2^18
  localparam int unsigned RATE_W      = 25;           // Width holding the generator rate

  // ****************************************************************
  // Channels and settings
  // ****************************************************************
  localparam int unsigned NUM_CH      = 7;            // Channels 0 to 6
  localparam int unsigned CH_W        = 3;            // Channel index width
  localparam int unsigned FREQ_W      = 20;           // Frequency setting width
  localparam logic [19:0] FREQ_MIN    = 20'h00001;    // 1 Hz
  localparam logic [19:0] FREQ_MAX    = 20'hf4240;    // 1 000 000 Hz
  localparam int unsigned DUTY_W      = 7;            // Duty setting width
  localparam logic [6:0]  DUTY_MAX    = 7'h64;        // 100 percent
  localparam int unsigned PER_W       = 25;           // Period count width in ticks
  localparam logic [24:0] PER_MIN     = 25'h0000001;  // Shortest period, one tick
  localparam logic [24:0] CNT_ZERO    = 25'h0000000;  // Counter restart value

  // ****************************************************************
  // Divider
  // ****************************************************************
  localparam int unsigned DIV_W       = 32;           // Dividend and quotient width
  localparam logic [5:0]  DIV_STEPS   = 6'h20;        // One step per quotient bit
  localparam logic [31:0] PCT_DIV     = 32'h00000064; // Percent divisor, 100
  localparam logic [31:0] PCT_HALF    = 32'h00000032; // Rounding term, 50

  // Setup sequencer states, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PER  = 4'b0010,
    S_HIGH = 4'b0100,
    S_LOAD = 4'b1000
  } setup_state_t;

endpackage : pwm_gen_pkg

// ---- hdl/pwm_chan_if.sv ----
// Carrier between the setup logic and one output channel
`timescale 1ns/10ps
`default_nettype none

interface pwm_chan_if;
  import pwm_gen_pkg::*;

  logic             tick;      // Shared generator clock tick
  logic             load;      // New counts are valid this cycle
  logic [PER_W-1:0] period;    // Cycle length in ticks
  logic [PER_W-1:0] high;      // High time in ticks
  logic             start;     // Start request pulse
  logic             stop;      // Stop request pulse
  logic             irqEn;     // Completion event enable
  logic             pinOut;    // Pin level
  logic             pinOe_n;   // Pin driver enable, low drives
  logic             done;      // Cycle completed pulse

  modport ctl  (output tick, load, period, high, start, stop, irqEn,
                input  pinOut, pinOe_n, done);
  modport chan (input  tick, load, period, high, start, stop, irqEn,
                output pinOut, pinOe_n, done);
endinterface : pwm_chan_if

`default_nettype wire

// ---- hdl/pwm_channel.sv ----
// One output channel: cycle counter, shadow counts, pin driver
`timescale 1ns/10ps
`default_nettype none

module pwm_channel
  import pwm_gen_pkg::*;
(
  input  wire logic mclk,   // System clock
  input  wire logic rst_n,  // Synchronous reset, active low
  input  wire logic ce,     // Clock enable
  pwm_chan_if.chan  ch      // Control and pin side
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic             cfgReg,  cfgNext;   // Counts have been loaded
  logic             runReg,  runNext;   // Stays running after this cycle
  logic             armReg,  armNext;   // Start seen, first cycle owed
  logic             actReg,  actNext;   // A cycle is in progress
  logic [PER_W-1:0] cntReg,  cntNext;   // Tick position in the cycle
  logic [PER_W-1:0] perReg,  perNext;   // Active period
  logic [PER_W-1:0] hiReg,   hiNext;    // Active high time
  logic [PER_W-1:0] pPerReg, pPerNext;  // Pending period
  logic [PER_W-1:0] pHiReg,  pHiNext;   // Pending high time
  logic             pinReg,  pinNext;   // Registered pin level
  logic             oeReg,   oeNext;    // Registered driver enable, low drives
  logic             doneReg, doneNext;  // Completion pulse

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic lastTick = actReg && ch.tick && (cntReg == perReg - PER_MIN); // Cycle end
  wire logic keepGoing = runNext;                                         // Stop not pending
  wire logic launch   = !actReg && ch.tick && cfgReg && (armReg || runReg); // Fresh cycle

  // Next state of the channel
  always_comb begin
    cfgNext  = cfgReg || ch.load;
    // Start wins over a stop in the same cycle
    runNext  = ch.start ? 1'b1 : (ch.stop ? 1'b0 : runReg);
    armNext  = armReg || ch.start;
    actNext  = actReg;
    cntNext  = cntReg;
    perNext  = perReg;
    hiNext   = hiReg;
    pPerNext = ch.load ? ch.period : pPerReg;
    pHiNext  = ch.load ? ch.high   : pHiReg;
    doneNext = 1'b0;
    if (launch) begin
      // Begin a cycle on a tick boundary with the latest counts
      actNext = 1'b1;
      armNext = ch.start;
      cntNext = CNT_ZERO;
      perNext = pPerNext;
      hiNext  = pHiNext;
    end else if (lastTick) begin
      doneNext = ch.irqEn;
      if (keepGoing) begin
        // New counts only at the boundary, so no cycle is cut short
        cntNext = CNT_ZERO;
        perNext = pPerNext;
        hiNext  = pHiNext;
        armNext = 1'b0;
      end else begin
        // Stop pending: finish here, pin falls low and stays driven
        actNext = 1'b0;
        armNext = ch.start;
      end
    end else if (actReg && ch.tick) begin
      cntNext = cntReg + PER_MIN;
    end
    // High while below the high-time count, low otherwise and when idle
    pinNext  = actNext && (cntNext < hiNext);
    // Input until configured, then driven for good
    oeNext   = !cfgNext;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Whole state frozen while ce is low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfgReg  <= 1'b0;
      runReg  <= 1'b0;
      armReg  <= 1'b0;
      actReg  <= 1'b0;
      cntReg  <= CNT_ZERO;
      perReg  <= PER_MIN;
      hiReg   <= CNT_ZERO;
      pPerReg <= PER_MIN;
      pHiReg  <= CNT_ZERO;
      pinReg  <= 1'b0;
      oeReg   <= 1'b1;
      doneReg <= 1'b0;
    end else if (ce) begin
      cfgReg  <= cfgNext;
      runReg  <= runNext;
      armReg  <= armNext;
      actReg  <= actNext;
      cntReg  <= cntNext;
      perReg  <= perNext;
      hiReg   <= hiNext;
      pPerReg <= pPerNext;
      pHiReg  <= pHiNext;
      pinReg  <= pinNext;
      oeReg   <= oeNext;
      doneReg <= doneNext;
    end
  end

  assign ch.pinOut  = pinReg;
  assign ch.pinOe_n = oeReg;
  assign ch.done    = doneReg;

endmodule // pwm_channel

`default_nettype wire

// ---- hdl/multi_channel_pwm_generator.sv ----
// Top of the seven-channel pulse generator with shared prescaler
// How it works
// - Seven independent channels, each its own pin.
// - Frequency setting accepted from 1 to 1000000.
// - Duty setting 0 to 100 percent high.
// - Setup before start: pin drives low.
// - Cycle starts high, then low, repeats.
// - Start before setup: input, then runs.
// - Stop finishes current cycle, none after.
// - Stopped pin stays driven low.
// - Enabled event pulses at each cycle end.
// - One shared generator clock for all.
// - Generator rate from discrete selectable set.
// - Pin levels change only on generator ticks.
// - Period is rounded rate over frequency.
`timescale 1ns/10ps
`default_nettype none

module multi_channel_pwm_generator
  import pwm_gen_pkg::*;
(
  input  wire logic              mclk,         // System clock, 25 MHz
  input  wire logic              rst_n,        // Synchronous reset, active low
  input  wire logic              ce,           // Clock enable, freezes all state
  input  wire logic [4:0]        clkSel,       // Generator rate = 25 MHz / 2^clkSel, values above 18 act as 18
  input  wire logic              setupValid,   // Setup request
  output logic                   setupReady,   // Setup sequencer idle
  input  wire logic [CH_W-1:0]   setupChan,    // Channel to set up
  input  wire logic [FREQ_W-1:0] setupFreq,    // Output frequency in hertz
  input  wire logic [DUTY_W-1:0] setupDuty,    // Percent high
  input  wire logic [NUM_CH-1:0] startReq,     // Start pulses, one per channel
  input  wire logic [NUM_CH-1:0] stopReq,      // Stop pulses, one per channel
  input  wire logic [NUM_CH-1:0] irqEnable,    // Completion event enables
  output logic      [NUM_CH-1:0] pwmOut,       // Pin output levels
  output logic      [NUM_CH-1:0] pwmOe_n,      // Pin driver enables, low drives
  output logic      [NUM_CH-1:0] cycleIrq      // Cycle completed pulses
);

  // ****************************************************************
  // Shared divider step
  // ****************************************************************
  // One restoring step: returns {remainder, quotient}
  function automatic logic [2*DIV_W:0] divStep(input logic [DIV_W:0]   remIn,
                                               input logic [DIV_W-1:0] quoIn,
                                               input logic [DIV_W-1:0] dvsr);
    logic [DIV_W:0]   r;
    logic [DIV_W-1:0] q;
    r = {remIn[DIV_W-1:0], quoIn[DIV_W-1]};
    q = {quoIn[DIV_W-2:0], 1'b0};
    if (r >= {1'b0, dvsr}) begin
      r    = r - {1'b0, dvsr};
      q[0] = 1'b1;
    end
    return {r, q};
  endfunction

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  logic [PRESC_W-1:0] prescReg;                     // Free-running prescaler
  wire  logic [4:0]   selEff = (clkSel > SEL_MAX) ? SEL_MAX : clkSel; // Clamp to slowest
  wire  logic [PRESC_W-1:0] selMask = PRESC_W'((19'h00001 << selEff) - 19'h00001);
  // Changing the rate retimes every running channel at once
  wire  logic tick = ((prescReg & selMask) == selMask);

  // Prescaler advances every enabled cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prescReg <= '0;
    end else if (ce) begin
      prescReg <= prescReg + PRESC_W'(1);
    end
  end

  // ****************************************************************
  // Setup sequencer
  // ****************************************************************
  setup_state_t       stReg, stNext;       // Sequencer state
  logic [CH_W-1:0]    chanReg;             // Channel being set up
  logic [DUTY_W-1:0]  dutyReg;             // Clamped duty
  logic [DIV_W-1:0]   dvsrReg;             // Current divisor
  logic [DIV_W:0]     remReg;              // Partial remainder
  logic [DIV_W-1:0]   quoReg;              // Shifting dividend and quotient
  logic [5:0]         stepReg;             // Steps left
  logic [PER_W-1:0]   perReg;              // Resulting period
  logic [PER_W-1:0]   hiReg;               // Resulting high time

  wire logic [FREQ_W-1:0] freqClamp = (setupFreq < FREQ_MIN) ? FREQ_MIN :
                                      ((setupFreq > FREQ_MAX) ? FREQ_MAX : setupFreq);
  wire logic [DUTY_W-1:0] dutyClamp = (setupDuty > DUTY_MAX) ? DUTY_MAX : setupDuty;
  wire logic [RATE_W-1:0] genRate   = RATE_W'(MCLK_HZ >> selEff);
  // Rounded quotient: (rate + freq/2) / freq
  wire logic [DIV_W-1:0]  perDividend = DIV_W'(genRate) + DIV_W'(freqClamp >> 1);
  wire logic [2*DIV_W:0]  stepOut   = divStep(remReg, quoReg, dvsrReg);
  wire logic              accept    = setupValid && (stReg == S_IDLE);
  wire logic              divLast   = (stepReg == 6'h01);
  // A zero quotient means the frequency is above the rate: use one tick
  wire logic [PER_W-1:0]  perResult = (stepOut[DIV_W-1:0] == '0) ? PER_MIN : stepOut[PER_W-1:0];
  // High time rounded: (period * duty + 50) / 100
  wire logic [DIV_W-1:0]  hiDividend = DIV_W'(perResult) * DIV_W'(dutyReg) + PCT_HALF;

  assign setupReady = (stReg == S_IDLE);

  // Next sequencer state
  always_comb begin
    case (stReg)
      S_IDLE:  stNext = accept ? S_PER : S_IDLE;
      S_PER:   stNext = divLast ? S_HIGH : S_PER;
      S_HIGH:  stNext = divLast ? S_LOAD : S_HIGH;
      S_LOAD:  stNext = S_IDLE;
      default: stNext = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stReg <= S_IDLE;
    end else if (ce) begin
      stReg <= stNext;
    end
  end

  // Divider datapath; serial to keep the area of two dividers down
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chanReg <= '0;
      dutyReg <= '0;
      dvsrReg <= '0;
      remReg  <= '0;
      quoReg  <= '0;
      stepReg <= '0;
      perReg  <= PER_MIN;
      hiReg   <= '0;
    end else if (ce) begin
      if (accept) begin
        // Latch request, start the period division
        chanReg <= setupChan;
        dutyReg <= dutyClamp;
        dvsrReg <= DIV_W'(freqClamp);
        remReg  <= '0;
        quoReg  <= perDividend;
        stepReg <= DIV_STEPS;
      end else if (stReg == S_PER && divLast) begin
        // Period done, start the high-time division
        perReg  <= perResult;
        dvsrReg <= PCT_DIV;
        remReg  <= '0;
        quoReg  <= hiDividend;
        stepReg <= DIV_STEPS;
      end else if (stReg == S_HIGH && divLast) begin
        hiReg   <= stepOut[PER_W-1:0];
        stepReg <= '0;
      end else if (stReg == S_PER || stReg == S_HIGH) begin
        remReg  <= stepOut[2*DIV_W:DIV_W];
        quoReg  <= stepOut[DIV_W-1:0];
        stepReg <= stepReg - 6'h01;
      end
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  pwm_chan_if chIf [NUM_CH] ();   // One carrier per channel

  // Each channel runs on its own, sharing only the tick
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign chIf[i].tick   = tick;
    assign chIf[i].load   = (stReg == S_LOAD) && (chanReg == CH_W'(i));
    assign chIf[i].period = perReg;
    assign chIf[i].high   = hiReg;
    assign chIf[i].start  = startReq[i];
    assign chIf[i].stop   = stopReq[i];
    assign chIf[i].irqEn  = irqEnable[i];
    assign pwmOut[i]      = chIf[i].pinOut;
    assign pwmOe_n[i]     = chIf[i].pinOe_n;
    assign cycleIrq[i]    = chIf[i].done;

    pwm_channel u_ch (
      .mclk  (mclk),
      .rst_n (rst_n),
      .ce    (ce),
      .ch    (chIf[i])
    );
  end

endmodule // multi_channel_pwm_generator

`default_nettype wire

// ---- bench/multi_channel_pwm_generator_sva.sv ----
// Checker of the pulse generator top ports
`timescale 1ns/10ps
`default_nettype none

module pwm_gen_sva
  import pwm_gen_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              ce,
  input wire logic [4:0]        clkSel,
  input wire logic              setupValid,
  input wire logic              setupReady,
  input wire logic [CH_W-1:0]   setupChan,
  input wire logic [FREQ_W-1:0] setupFreq,
  input wire logic [DUTY_W-1:0] setupDuty,
  input wire logic [NUM_CH-1:0] startReq,
  input wire logic [NUM_CH-1:0] stopReq,
  input wire logic [NUM_CH-1:0] irqEnable,
  input wire logic [NUM_CH-1:0] pwmOut,
  input wire logic [NUM_CH-1:0] pwmOe_n,
  input wire logic [NUM_CH-1:0] cycleIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****************
  // Setup handshake
  // ****************
  wire logic take;  // Request accepted this edge
  assign take = ce && setupValid && setupReady;
  chk_ready_low: assert property (take |=> (!setupReady) [*8])
    else $error("setup ready returned early");
  chk_ready_back: assert property (take |-> ##[66:68] setupReady)
    else $error("setup ready did not return");
  chk_ready_cause: assert property ($fell(setupReady) |-> $past(setupValid))
    else $error("setup started without request");
  // ****************
  // Pin drivers
  // ****************
  chk_oe_on_load: assert property ((($past(pwmOe_n) & ~pwmOe_n) != 7'h00) |-> $rose(setupReady))
    else $error("pin driven without a completed setup");
  chk_oe_sticky: assert property ($past(rst_n) |-> ((~$past(pwmOe_n) & pwmOe_n) == 7'h00))
    else $error("driven pin released");
  chk_out_needs_oe: assert property ((pwmOut & pwmOe_n) == 7'h00)
    else $error("waveform on undriven pin");
  chk_irq_enable: assert property ((cycleIrq & ~irqEnable & ~$past(irqEnable)) == 7'h00)
    else $error("event while disabled");
  chk_tick_only: assert property (($past(rst_n) && clkSel != 5'h00 && $past(clkSel) != 5'h00
    && $changed(pwmOut)) |=> !$changed(pwmOut))
    else $error("pin changed between ticks");
  // Main scenarios reached
  cover property (take);
  cover property (cycleIrq != 7'h00);
  cover property (stopReq != 7'h00);
endmodule // pwm_gen_sva

bind multi_channel_pwm_generator pwm_gen_sva chk (.mclk(mclk), .rst_n(rst_n), .ce(ce), .clkSel(clkSel),
  .setupValid(setupValid), .setupReady(setupReady), .setupChan(setupChan), .setupFreq(setupFreq),
  .setupDuty(setupDuty), .startReq(startReq), .stopReq(stopReq), .irqEnable(irqEnable),
  .pwmOut(pwmOut), .pwmOe_n(pwmOe_n), .cycleIrq(cycleIrq));

`default_nettype wire

// ---- bench/pwm_load_model.sv ----
// Load model standing on the seven pulse pins
`timescale 1ns/10ps
`default_nettype none

module pwm_load_model
  import pwm_gen_pkg::*;
(
  input  wire logic              mclk,     // System clock
  input  wire logic              rst_n,    // Reset, active low
  input  wire logic [NUM_CH-1:0] pwmOut,   // Pin levels from the block
  input  wire logic [NUM_CH-1:0] pwmOe_n,  // Driver enables, low drives
  output logic      [NUM_CH-1:0] pinLevel  // Level the load sees
);
  logic [NUM_CH-1:0] lastLevel;  // Level of the previous cycle
  // ****************
  // Wire level
  // ****************
  // No pull resistor, so an undriven pin drifts rather than holding its last level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lastLevel <= '0;
    end else begin
      lastLevel <= pinLevel;
    end
  end
  assign pinLevel = (pwmOut & ~pwmOe_n) | (~lastLevel & pwmOe_n);
endmodule // pwm_load_model

`default_nettype wire

// ---- bench/multi_channel_pwm_generator_tb.sv ----
// Self-checking bench of the seven-channel pulse generator
`timescale 1ns/10ps
`default_nettype none

module multi_channel_pwm_generator_tb;
  import pwm_gen_pkg::*;
  logic              mclk;       // System clock, 25 MHz
  logic              rst_n;      // Reset, active low
  logic              ce;         // Clock enable
  logic [NUM_CH-1:0] frozen;     // Pins seen as the freeze began
  logic [4:0]        clkSel;     // Generator rate select
  logic              setupValid; // Setup request
  logic [CH_W-1:0]   setupChan;  // Channel to set up
  logic [FREQ_W-1:0] setupFreq;  // Frequency in hertz
  logic [DUTY_W-1:0] setupDuty;  // Percent high
  logic [NUM_CH-1:0] startReq;   // Start pulses
  logic [NUM_CH-1:0] stopReq;    // Stop pulses
  logic [NUM_CH-1:0] irqEnable;  // Event enables
  wire logic              setupReady; // Sequencer idle
  wire logic [NUM_CH-1:0] pwmOut;     // Pin levels
  wire logic [NUM_CH-1:0] pwmOe_n;    // Driver enables
  wire logic [NUM_CH-1:0] cycleIrq;   // Cycle events
  wire logic [NUM_CH-1:0] pinLevel;   // Level seen by loads
  int                nErrors;    // Mismatches
  int                checksDone; // Comparisons
  int                hi;         // High samples in a run
  int                ir;         // Events in a run

  multi_channel_pwm_generator DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce), .clkSel(clkSel),
    .setupValid(setupValid), .setupReady(setupReady), .setupChan(setupChan), .setupFreq(setupFreq),
    .setupDuty(setupDuty), .startReq(startReq), .stopReq(stopReq), .irqEnable(irqEnable),
    .pwmOut(pwmOut), .pwmOe_n(pwmOe_n), .cycleIrq(cycleIrq));
  pwm_load_model LOAD (.mclk(mclk), .rst_n(rst_n), .pwmOut(pwmOut), .pwmOe_n(pwmOe_n), .pinLevel(pinLevel));

  // ****************
  // Shared tasks
  // ****************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // One request, held for one cycle, then wait for the sequencer to come back
  task automatic setup(input logic [CH_W-1:0] ch, input logic [FREQ_W-1:0] f, input logic [DUTY_W-1:0] d);
    int k;
    @(posedge mclk);
    setupValid <= 1'b1;
    setupChan <= ch;
    setupFreq <= f;
    setupDuty <= d;
    @(posedge mclk);
    setupValid <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (setupReady !== 1'b1 && k < 100);
    check("setup done", 1, k < 100);
  endtask
  // Counts high samples and events over n cycles, pulsing start or stop at given cycles
  task automatic run(input int ch, input int n, input int sa, input int so, output int h, output int e);
    h = 0;
    e = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      startReq[ch] <= (i == sa);
      stopReq[ch] <= (i == so);
      #1;
      h += (pwmOut[ch] === 1'b1);
      e += (cycleIrq[ch] === 1'b1);
    end
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_setup_first();
    check("oe before setup", 1, pwmOe_n[0]);
    setup(0, 20'hf4240, 7'h28);
    check("oe after setup", 0, pwmOe_n[0]);
    run(0, 30, -1, -1, hi, ir);
    check("low before start", 0, hi);
    run(0, 100, 0, -1, hi, ir);
    check("first highs", 40, hi);
    check("first events", 3, ir);
    run(0, 100, -1, -1, hi, ir);
    check("highs per 4 cycles", 40, hi);
    check("events per 4 cycles", 4, ir);
    @(posedge mclk);
    irqEnable <= 7'h7e;
    run(0, 100, -1, -1, hi, ir);
    check("masked events", 0, ir);
    @(posedge mclk);
    irqEnable <= 7'h7f;
    $display("test setup_first done");
  endtask
  task automatic t_retune_stop();
    setup(0, 20'hf4240, 7'h50);
    run(0, 30, -1, -1, hi, ir);
    run(0, 100, -1, -1, hi, ir);
    check("retuned highs", 80, hi);
    run(0, 60, -1, 3, hi, ir);
    run(0, 100, -1, -1, hi, ir);
    check("stopped highs", 0, hi);
    check("stopped oe", 0, pwmOe_n[0]);
    check("stopped pin", 0, pinLevel[0]);
    run(0, 100, 0, 1, hi, ir);
    check("single cycle highs", 20, hi);
    check("single cycle events", 1, ir);
    $display("test retune_stop done");
  endtask
  task automatic t_start_first();
    run(1, 10, 0, -1, hi, ir);
    check("input until setup", 1, pwmOe_n[1]);
    setup(1, 20'hf4240, 7'h28);
    check("driven after setup", 0, pwmOe_n[1]);
    run(1, 100, -1, -1, hi, ir);
    check("runs after setup", 40, hi);
    $display("test start_first done");
  endtask
  task automatic t_duty_ends();
    setup(2, 20'hf4240, 7'h64);
    run(2, 10, 0, -1, hi, ir);
    run(2, 100, -1, -1, hi, ir);
    check("full duty", 100, hi);
    setup(3, 20'hf4240, 7'h00);
    run(3, 100, 0, -1, hi, ir);
    check("zero duty", 0, hi);
    check("zero duty events", 3, ir);
    $display("test duty_ends done");
  endtask
  task automatic t_rounding();
    setup(4, 20'h927c0, 7'h32);
    run(4, 50, 0, -1, hi, ir);
    run(4, 84, -1, -1, hi, ir);
    check("rounded highs", 42, hi);
    check("rounded events", 2, ir);
    setup(6, 20'hfffff, 7'h28);
    run(6, 20, 0, -1, hi, ir);
    run(6, 100, -1, -1, hi, ir);
    check("clamped highs", 40, hi);
    check("clamped events", 4, ir);
    $display("test rounding done");
  endtask
  task automatic t_rate();
    @(posedge mclk);
    clkSel <= 5'h01;
    run(1, 60, -1, -1, hi, ir);
    run(1, 100, -1, -1, hi, ir);
    check("slowed highs", 40, hi);
    check("slowed events", 2, ir);
    $display("test rate done");
  endtask
  // Enable low: running channels must hold their pins
  task automatic t_freeze();
    @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    #1;
    frozen = pwmOut;
    repeat (20) @(posedge mclk);
    #1;
    check("frozen pins", frozen, pwmOut);
    @(posedge mclk);
    ce <= 1'b1;
    $display("test freeze done");
  endtask

  // ****************
  // Clock, watchdog, sequence
  // ****************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Whole run is about 2000 cycles; allow several times that
  initial begin
    #400000;
    nErrors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    conclude();
  end
  initial begin
    nErrors = 0;
    checksDone = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    frozen = '0;
    clkSel = 5'h00;
    setupValid = 1'b0;
    setupChan = '0;
    setupFreq = '0;
    setupDuty = '0;
    startReq = '0;
    stopReq = '0;
    irqEnable = 7'h7f;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_setup_first();
    t_retune_stop();
    t_start_first();
    t_duty_ends();
    t_rounding();
    t_rate();
    t_freeze();
    conclude();
  end
endmodule // multi_channel_pwm_generator_tb

`default_nettype wire
